// ### verilog/csp_pkg.sv
// What this block does
// - Wake delay code sits at 0x000 bits 3:2.
// - Codes 00-11 give 200/400/600/800 ms waits.
// - Low power period is conversions plus delay.
// - Raw 16-bit result readable at 0x00B.
// - Each input: negative, positive, floating or bias.
// - Up to 12 stages, own routing each.
// - Two-bit routing code per input per stage.
// - Stage0 0xFFBF/0x2FFF: fourth input positive.
// - Stage5 0xFFFE/0x37FF: first pos, thirteenth neg.
// - Positive raises code, negative lowers it.
// - Match field 13:12: 01 neg, 10 pos, 11 diff.
// - Proximity immediately disables environmental calibration.
// - Calibration stays off for hold-off after release.
// - Full power hold-off: count x16 periods.
// - Low power hold-off: count x4 periods.
// - Ambient frozen while proximity flag is set.
// - Persistent deviation over level forces recalibration.
// - Full power timeout: count x full periods.
// - Low power timeout: count x low periods.
// - Recalibrate at timeout end despite proximity.
// - Hold-off counts at 0x002 bits 7:4, 11:8.
// - Recal counts at 0x004 bits 9:0, 15:10.
// - Deviation threshold is 0x003 bits 7:0 x16.
package csp_pkg;
  // ***********************************************
  // Register map and field layout.
  // ***********************************************
  localparam logic [11:0] REG_PWR_CTRL = 12'h000;
  localparam logic [11:0] REG_PROX_CNT = 12'h002;
  localparam logic [11:0] REG_PROX_LVL = 12'h003;
  localparam logic [11:0] REG_PROX_RECAL = 12'h004;
  localparam logic [11:0] REG_RAW_RESULT = 12'h00B;
  localparam int WAKE_DLY_LSB = 2;
  localparam int FP_CALDIS_LSB = 4;
  localparam int LP_CALDIS_LSB = 8;
  localparam int DEV_LVL_LSB = 0;
  localparam int FP_RECAL_LSB = 0;
  localparam int LP_RECAL_LSB = 10;
  localparam int SE_MATCH_LSB = 12;
  localparam int NUM_INPUTS = 13;
  localparam int LO_INPUTS = 7;
  localparam int NUM_STAGES = 12;
  localparam logic [3:0] LAST_STAGE_MAX = 4'hB;
  localparam int FP_CALDIS_SHIFT = 4;
  localparam int LP_CALDIS_SHIFT = 2;
  localparam int DEV_LVL_SHIFT = 4;
  localparam logic [15:0] ROUTE_RST = 16'h0000;
  localparam logic [15:0] AMB_RST = 16'h0000;
  // ***********************************************
  // Timing.
  // ***********************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int WAKE_STEP_MS = 200;
  localparam int WAKE_STEP_CYC = WAKE_STEP_MS * (CLK_HZ / 1000);
  // ***********************************************
  // Codes.
  // ***********************************************
  typedef enum logic [1:0] {
    RT_FLOAT = 2'h0,
    RT_NEG = 2'h1,
    RT_POS = 2'h2,
    RT_BIAS = 2'h3
  } csp_route_t;
  localparam logic [1:0] SE_INVALID = 2'h0;
  localparam logic [1:0] SE_DIFF = 2'h3;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_START = 4'h2,
    S_CONV = 4'h4,
    S_WAIT = 4'h8
  } csp_state_t;
endpackage

// ### verilog/csp_route_dec.sv
`timescale 1ns/1ps
`default_nettype none
module csp_route_dec
  import csp_pkg::*;
(
  input wire logic [15:0] i_lo_word,
  input wire logic [15:0] i_hi_word,
  output logic [NUM_INPUTS-1:0] o_pos,
  output logic [NUM_INPUTS-1:0] o_neg,
  output logic [NUM_INPUTS-1:0] o_bias,
  output logic [1:0] o_se_match
);
  // Picks one input's two-bit code from the low or high word.
  function automatic logic [1:0] code_of(input logic [15:0] lo,
                                         input logic [15:0] hi,
                                         input int n);
    logic [1:0] c;
    if (n < LO_INPUTS) begin
      c = lo[2*n +: 2];
    end else begin
      c = hi[2*(n-LO_INPUTS) +: 2];
    end
    return c;
  endfunction

  // ***********************************************
  // Per-input decode into terminal masks.
  // ***********************************************
  for (genvar n = 0; n < NUM_INPUTS; n++) begin : g_in
    // A floating input sets none of the three masks.
    assign o_pos[n] = code_of(i_lo_word, i_hi_word, n) == RT_POS;
    assign o_neg[n] = code_of(i_lo_word, i_hi_word, n) == RT_NEG;
    assign o_bias[n] = code_of(i_lo_word, i_hi_word, n) == RT_BIAS;
  end
  // Matching field rides in the high word above the inputs.
  assign o_se_match = i_hi_word[SE_MATCH_LSB +: 2];
endmodule
`default_nettype wire

// ### verilog/csp_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
module csp_wake_timer
  import csp_pkg::*;
#(
  parameter int STEP_CYC = WAKE_STEP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [1:0] i_code,
  output logic o_done_ff
);
  localparam int CW = $clog2(4 * STEP_CYC + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] target;
  logic busy_ff;

  // Code n waits (n+1) steps, so 00 is one step, 11 four.
  assign target = CW'((32'(i_code) + 32'd1) * 32'(STEP_CYC));

  // ***********************************************
  // Delay counter.
  // ***********************************************
  // Code is sampled every cycle; host must hold it steady in a wait.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      o_done_ff <= 1'b0;
    end else begin
      o_done_ff <= 1'b0;
      if (i_start) begin
        cnt_ff <= CW'(1);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff >= target) begin
          busy_ff <= 1'b0;
          o_done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + CW'(1);
        end
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_wake_len: assert property (o_done_ff |-> $past(cnt_ff) == $past(target))
    else $error("wake delay length wrong");
  cov_wake_done: cover property (o_done_ff);
endmodule
`default_nettype wire

// ### verilog/csp_prox_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csp_prox_ctrl
  import csp_pkg::*;
#(
  parameter int WAKE_STEP = WAKE_STEP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_lowpower_mode,
  input wire logic [3:0] i_last_stage,
  input wire logic [15:0] i_pwr_ctrl,
  input wire logic [15:0] i_prox_cnt_reg,
  input wire logic [15:0] i_prox_lvl_reg,
  input wire logic [15:0] i_prox_recal_reg,
  input wire logic i_route_wr,
  input wire logic [3:0] i_route_stage,
  input wire logic i_route_hi,
  input wire logic [15:0] i_route_data,
  input wire logic i_conv_valid,
  input wire logic [15:0] i_conv_data,
  input wire logic i_proximity,
  output logic o_conv_start_ff,
  output logic [3:0] o_stage_ff,
  output logic [NUM_INPUTS-1:0] o_route_pos_ff,
  output logic [NUM_INPUTS-1:0] o_route_neg_ff,
  output logic [NUM_INPUTS-1:0] o_route_bias_ff,
  output logic [1:0] o_se_match_ff,
  output logic o_se_invalid_ff,
  output logic [15:0] o_raw_result_ff,
  output logic o_raw_valid_ff,
  output logic o_period_end_ff,
  output logic o_cal_enabled_ff,
  output logic o_force_recal_ff,
  output logic [15:0] o_ambient_ff
);
  csp_state_t state_ff;
  logic [15:0] route_lo_ff [NUM_STAGES];
  logic [15:0] route_hi_ff [NUM_STAGES];
  logic [15:0] amb_ff [NUM_STAGES];
  logic [15:0] last_ff [NUM_STAGES];
  logic [NUM_INPUTS-1:0] dec_pos;
  logic [NUM_INPUTS-1:0] dec_neg;
  logic [NUM_INPUTS-1:0] dec_bias;
  logic [1:0] dec_se;
  logic [3:0] last_stg;
  logic at_last;
  logic seq_done;
  logic wait_done;
  logic period_end;
  logic [16:0] dev_limit;
  logic dev_hit;
  logic seq_dev_ff;
  logic seq_has_dev;
  logic [9:0] recal_target;
  logic [9:0] dev_cnt_ff;
  logic recal_now;
  logic [7:0] hold_target;
  logic [7:0] hold_cnt_ff;

  // ***********************************************
  // Field extraction and timing targets.
  // ***********************************************
  // Stage counts beyond the last real stage are clamped.
  assign last_stg = (i_last_stage > LAST_STAGE_MAX) ? LAST_STAGE_MAX
                                                    : i_last_stage;
  // A last stage lowered mid-sequence ends it at once; equality alone
  // would let the stage count run past the stored stages.
  assign at_last = o_stage_ff >= last_stg;
  assign seq_done = (state_ff == S_CONV) && i_conv_valid && at_last;
  // Full power period ends on the last result; low power adds the wait.
  assign period_end = (seq_done && !i_lowpower_mode)
                      || ((state_ff == S_WAIT) && wait_done);
  // Level is in units of 16 codes; 17 bits keep the sum from wrapping.
  assign dev_limit = {1'b0, amb_ff[o_stage_ff]}
                     + {5'h00, i_prox_lvl_reg[DEV_LVL_LSB +: 8], 4'h0};
  assign dev_hit = i_conv_valid && ({1'b0, i_conv_data} > dev_limit);
  assign seq_has_dev = seq_dev_ff || dev_hit;
  // Timeouts are counted in whole periods of the current mode.
  assign recal_target = i_lowpower_mode
                        ? {4'h0, i_prox_recal_reg[LP_RECAL_LSB +: 6]}
                        : i_prox_recal_reg[FP_RECAL_LSB +: 10];
  assign recal_now = period_end && seq_has_dev && (recal_target != 10'h000)
                     && (dev_cnt_ff + 10'h001 >= recal_target);
  assign hold_target = i_lowpower_mode
    ? 8'({i_prox_cnt_reg[LP_CALDIS_LSB +: 4], 2'h0})
    : 8'({i_prox_cnt_reg[FP_CALDIS_LSB +: 4], 4'h0});

  csp_route_dec u_dec (
    .i_lo_word(route_lo_ff[o_stage_ff]),
    .i_hi_word(route_hi_ff[o_stage_ff]),
    .o_pos(dec_pos),
    .o_neg(dec_neg),
    .o_bias(dec_bias),
    .o_se_match(dec_se)
  );

  csp_wake_timer #(.STEP_CYC(WAKE_STEP)) u_wake (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_start(seq_done && i_lowpower_mode),
    .i_code(i_pwr_ctrl[WAKE_DLY_LSB +: 2]),
    .o_done_ff(wait_done)
  );

  // ***********************************************
  // Conversion sequencer.
  // ***********************************************
  // Disabling takes effect at the next stage boundary only.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= S_IDLE;
      o_stage_ff <= 4'h0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          o_stage_ff <= 4'h0;
          if (i_enable) begin
            state_ff <= S_START;
          end
        end
        S_START: begin
          state_ff <= i_enable ? S_CONV : S_IDLE;
        end
        S_CONV: begin
          if (i_conv_valid) begin
            if (!at_last) begin
              o_stage_ff <= o_stage_ff + 4'h1;
              state_ff <= S_START;
            end else begin
              o_stage_ff <= 4'h0;
              state_ff <= i_lowpower_mode ? S_WAIT : S_START;
            end
          end
        end
        S_WAIT: begin
          if (wait_done) begin
            state_ff <= S_START;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Start pulse and routing go out together for each stage.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conv_start_ff <= 1'b0;
      o_route_pos_ff <= '0;
      o_route_neg_ff <= '0;
      o_route_bias_ff <= '0;
      o_se_match_ff <= SE_INVALID;
      o_se_invalid_ff <= 1'b1;
    end else begin
      o_conv_start_ff <= (state_ff == S_START) && i_enable;
      if (state_ff == S_START) begin
        o_route_pos_ff <= dec_pos;
        o_route_neg_ff <= dec_neg;
        o_route_bias_ff <= dec_bias;
        o_se_match_ff <= dec_se;
        o_se_invalid_ff <= dec_se == SE_INVALID;
      end
    end
  end

  // ***********************************************
  // Routing store, one word pair per stage.
  // ***********************************************
  // Writes to stage numbers beyond the last are dropped.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STAGES; s++) begin
        route_lo_ff[s] <= ROUTE_RST;
        route_hi_ff[s] <= ROUTE_RST;
      end
    end else if (i_route_wr && (i_route_stage <= LAST_STAGE_MAX)) begin
      if (i_route_hi) begin
        route_hi_ff[i_route_stage] <= i_route_data;
      end else begin
        route_lo_ff[i_route_stage] <= i_route_data;
      end
    end
  end

  // ***********************************************
  // Raw result readback.
  // ***********************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_raw_result_ff <= 16'h0000;
      o_raw_valid_ff <= 1'b0;
      o_period_end_ff <= 1'b0;
    end else begin
      o_raw_valid_ff <= i_conv_valid;
      o_period_end_ff <= period_end;
      if (i_conv_valid) begin
        o_raw_result_ff <= i_conv_data;
      end
    end
  end

  // ***********************************************
  // Calibration disable and hold-off.
  // ***********************************************
  // Proximity clears the enable in the very next cycle, no period wait.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cal_enabled_ff <= 1'b1;
      hold_cnt_ff <= 8'h00;
    end else if (i_proximity) begin
      o_cal_enabled_ff <= 1'b0;
      hold_cnt_ff <= 8'h00;
    end else if (!o_cal_enabled_ff && period_end) begin
      if (hold_cnt_ff + 8'h01 >= hold_target) begin
        o_cal_enabled_ff <= 1'b1;
      end else begin
        hold_cnt_ff <= hold_cnt_ff + 8'h01;
      end
    end
  end

  // ***********************************************
  // Deviation timeout and forced recalibration.
  // ***********************************************
  // One clean period restarts the timeout from zero.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      seq_dev_ff <= 1'b0;
      dev_cnt_ff <= 10'h000;
      o_force_recal_ff <= 1'b0;
    end else begin
      o_force_recal_ff <= recal_now;
      if (period_end) begin
        seq_dev_ff <= 1'b0;
        if (recal_now || !seq_has_dev) begin
          dev_cnt_ff <= 10'h000;
        end else begin
          dev_cnt_ff <= dev_cnt_ff + 10'h001;
        end
      end else if (dev_hit) begin
        seq_dev_ff <= 1'b1;
      end
    end
  end

  // ***********************************************
  // Ambient and last-measurement store.
  // ***********************************************
  // Recalibration copies the latest results in, ignoring proximity.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int s = 0; s < NUM_STAGES; s++) begin
        amb_ff[s] <= AMB_RST;
        last_ff[s] <= AMB_RST;
      end
      o_ambient_ff <= AMB_RST;
    end else begin
      if (i_conv_valid) begin
        last_ff[o_stage_ff] <= i_conv_data;
      end
      if (recal_now) begin
        for (int s = 0; s < NUM_STAGES; s++) begin
          amb_ff[s] <= (i_conv_valid && (o_stage_ff == 4'(s)))
                       ? i_conv_data : last_ff[s];
        end
      end else if (i_conv_valid && o_cal_enabled_ff && !i_proximity) begin
        amb_ff[o_stage_ff] <= i_conv_data;
        o_ambient_ff <= i_conv_data;
      end
    end
  end

  // ***********************************************
  // Checks.
  // ***********************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_prox_caldis: assert property (i_proximity |=> !o_cal_enabled_ff)
    else $error("calibration not disabled on proximity");
  chk_amb_frozen: assert property (i_proximity |=> $stable(o_ambient_ff))
    else $error("ambient updated during proximity");
  chk_raw_capture: assert property (i_conv_valid |=>
      o_raw_result_ff == $past(i_conv_data))
    else $error("raw result not captured");
  chk_route_apply: assert property ((state_ff == S_START) |=>
      o_route_pos_ff == $past(dec_pos) && o_se_match_ff == $past(dec_se))
    else $error("routing not applied at stage start");
  chk_stage_bound: assert property (o_stage_ff <= last_stg
      || $past(i_last_stage) != i_last_stage)
    else $error("stage beyond last");
  chk_cal_release: assert property ($rose(o_cal_enabled_ff) |->
      $past(period_end) && !$past(i_proximity))
    else $error("calibration released off a period end");
  chk_recal_count: assert property (o_force_recal_ff |->
      $past(dev_cnt_ff) + 10'h001 >= $past(recal_target))
    else $error("recalibration before timeout");
  chk_lp_period: assert property (period_end && i_lowpower_mode
      |-> state_ff == S_WAIT)
    else $error("low power period ended without wait");
  chk_se_flag: assert property (o_se_invalid_ff ==
      (o_se_match_ff == SE_INVALID))
    else $error("match invalid flag wrong");
  cov_recal: cover property (o_force_recal_ff && i_proximity);
  cov_release: cover property ($rose(o_cal_enabled_ff));
  cov_diff: cover property (o_conv_start_ff && o_se_match_ff == SE_DIFF);
endmodule
`default_nettype wire

// ### tb/csp_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_conv_model
  import csp_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic i_mclk,
  input wire logic i_start,
  input wire logic [NUM_INPUTS-1:0] i_pos,
  input wire logic [NUM_INPUTS-1:0] i_neg,
  input wire logic [NUM_INPUTS-1:0] i_touch,
  output logic o_valid,
  output logic [15:0] o_data
);
  int cnt;
  logic [15:0] val;
  // Quiet converter output so no result is flagged valid before the first start.
  initial begin
    cnt = 0;
    val = 16'h8000;
    o_valid = 1'b0;
    o_data = 16'h0000;
  end
  // A touched sensor on the positive terminal adds a step and on the
  // negative terminal removes one; outside a result the data bus toggles
  // so a stale value can never be mistaken for a fresh one.
  always @(posedge i_mclk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_valid <= 1'b1;
        o_data <= val;
      end
    end else if (i_start === 1'b1) begin
      cnt <= DLY;
      val <= 16'h8000 + 16'h0100 * 16'($countones(i_pos & i_touch))
        - 16'h0100 * 16'($countones(i_neg & i_touch));
    end
  end
endmodule
`default_nettype wire

// ### tb/csp_prox_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module csp_prox_ctrl_test
  import csp_pkg::*;
;
  // ***************************************************
  // Signals.
  // ***************************************************
  localparam int WS = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en, lp, rwr, rhi, cv, prox;
  logic start, sei, rawv, pe, cal, frc;
  logic [3:0] last, rstg, stg;
  logic [15:0] pwr, cnt_r, lvl_r, rec_r, rdat, cd, raw, amb;
  logic [12:0] touch, pos, neg, bias;
  logic [1:0] sem;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int g, g_fp, n, f;

  csp_prox_ctrl #(.WAKE_STEP(WS)) csp_prox_ctrl_inst (
    .i_mclk(clk),
    .i_sys_rst(rst),
    .i_enable(en),
    .i_lowpower_mode(lp),
    .i_last_stage(last),
    .i_pwr_ctrl(pwr),
    .i_prox_cnt_reg(cnt_r),
    .i_prox_lvl_reg(lvl_r),
    .i_prox_recal_reg(rec_r),
    .i_route_wr(rwr),
    .i_route_stage(rstg),
    .i_route_hi(rhi),
    .i_route_data(rdat),
    .i_conv_valid(cv),
    .i_conv_data(cd),
    .i_proximity(prox),
    .o_conv_start_ff(start),
    .o_stage_ff(stg),
    .o_route_pos_ff(pos),
    .o_route_neg_ff(neg),
    .o_route_bias_ff(bias),
    .o_se_match_ff(sem),
    .o_se_invalid_ff(sei),
    .o_raw_result_ff(raw),
    .o_raw_valid_ff(rawv),
    .o_period_end_ff(pe),
    .o_cal_enabled_ff(cal),
    .o_force_recal_ff(frc),
    .o_ambient_ff(amb)
  );

  csp_conv_model #(.DLY(3)) csp_conv_model_inst (
    .i_mclk(clk),
    .i_start(start),
    .i_pos(pos),
    .i_neg(neg),
    .i_touch(touch),
    .o_valid(cv),
    .o_data(cd)
  );

  // ***************************************************
  // Clock, watchdog and shared tasks.
  // ***************************************************
  // Free running 50 MHz clock.
  always #10 clk = ~clk;

  // A hung handshake would stall the run forever, so cap the cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Inputs always move one nanosecond after the rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic ev(input int w);
    return w == 0 ? start : (w == 1 ? rawv : pe);
  endfunction

  // Waits, bounded, until start, raw valid or period end is high.
  task automatic wait_ev(input int w);
    int k;
    k = 0;
    while (ev(w) !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
    if (k >= 3000) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // Cycles from one period end pulse to the next.
  task automatic gap(output int c);
    wait_ev(2);
    tick();
    c = 1;
    while (pe !== 1'b1 && c < 3000) begin
      tick();
      c++;
    end
  endtask

  // The strobe is left high so that writes can follow back to back.
  task automatic wr_route(input logic [3:0] s, input logic h,
                          input logic [15:0] d);
    rwr = 1'b1;
    rstg = s;
    rhi = h;
    rdat = d;
    tick();
  endtask

  // ***************************************************
  // Test sequence.
  // ***************************************************
  initial begin
    {en, lp, rwr, rhi, prox} = 5'h00;
    last = 4'h0;
    rstg = 4'h0;
    {pwr, lvl_r, rec_r, rdat} = 64'h0;
    cnt_r = 16'h0110;
    touch = 13'h0000;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    cmp(sei, 16'h0001);
    // Per-stage routing, then a dropped write to a stage that is absent.
    for (int s = 0; s < 12; s++) begin
      wr_route(s[3:0], 1'b0, s == 0 ? 16'hFFBF :
               (s == 5 ? 16'hFFFE : 16'hFFFF));
      wr_route(s[3:0], 1'b1, s == 0 ? 16'h2FFF :
               (s == 5 ? 16'h37FF : 16'h3FFF));
    end
    wr_route(4'hC, 1'b0, 16'h0000);
    rwr = 1'b0;
    last = 4'h5;
    touch = 13'h1008;
    en = 1'b1;
    for (int s = 0; s < 6; s++) begin
      wait_ev(0);
      cmp(16'(stg), 16'(s));
      cmp(pos, s == 0 ? 16'h0008 : (s == 5 ? 16'h0001 : 16'h0));
      cmp(neg, s == 5 ? 16'h1000 : 16'h0000);
      cmp(bias, s == 0 ? 16'h1FF7 : (s == 5 ? 16'h0FFE : 16'h1FFF));
      cmp(sem, s == 0 ? 16'h0002 : 16'h0003);
      cmp(sei, 16'h0000);
      tick();
      wait_ev(1);
      cmp(raw, s == 0 ? 16'h8100 : (s == 5 ? 16'h7F00 : 16'h8000));
      tick();
    end
    $display("test routing done");
    // Low power period is the full power period plus the wake delay and one cycle.
    last = 4'h0;
    touch = 13'h0000;
    gap(g);
    gap(g_fp);
    for (int c = 0; c < 4; c++) begin
      lp = 1'b1;
      pwr = {12'h000, c[1:0], 2'h0};
      gap(g);
      gap(g);
      cmp(16'(g - g_fp), 16'((c + 1) * WS + 1));
    end
    pwr = 16'h0000;
    $display("test wake delay done");
    // Calibration hold-off after proximity, full then low power.
    for (int m = 0; m < 2; m++) begin
      lp = m[0];
      wait_ev(2);
      tick();
      prox = 1'b1;
      tick();
      cmp(cal, 16'h0000);
      wait_ev(2);
      tick();
      prox = 1'b0;
      n = m == 1 ? 4 : 16;
      for (int i = 1; i <= n; i++) begin
        wait_ev(2);
        tick();
        if (i >= n - 1) cmp(cal, i == n ? 16'h1 : 16'h0);
      end
    end
    $display("test hold-off done");
    // Forced recalibration: deviation equal to the level, then above it.
    lp = 1'b0;
    wait_ev(2);
    tick();
    cmp(amb, 16'h8000);
    rec_r = 16'h0003;
    for (int l = 0; l < 2; l++) begin
      lvl_r = l == 1 ? 16'h000F : 16'h0010;
      wait_ev(2);
      tick();
      prox = 1'b1;
      touch = 13'h0008;
      for (int i = 1; i <= 3; i++) begin
        wait_ev(2);
        f = int'(frc === 1'b1);
        tick();
        f = f | int'(frc === 1'b1);
        cmp(16'(f), (l == 1 && i == 3) ? 16'h1 : 16'h0);
        if (i == 2) cmp(amb, 16'h8000);
      end
      prox = 1'b0;
      touch = 13'h0000;
    end
    $display("test recalibration done");
    print_verdict();
  end
endmodule
`default_nettype wire
